/* hw/esio_port.sv */
// eight-bit shared io port: registers, pin muxing and read-back
//
// How it works
// - eight two-way pins with alternate functions
// - same alternate functions in every mode
// - direction at ffd1, data at ffd3
// - direction bit 1 drives, 0 inputs
// - direction register write only, reads ones
// - direction clears on reset and hardware standby
// - software standby keeps direction and outputs
// - eight-bit read/write data register
// - read returns data if output, pin otherwise
// - data clears on reset/hw standby, kept otherwise
// - channel-2 b compare output owns bit 7
// - bit 7 input, output or pattern output
// - bit 7 feeds capture when top bit set and not in pwm mode
`timescale 1ns/100ps
`default_nettype none
module esio_port #(
  parameter int width = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic sw_standby,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pin_in,
  output logic [7:0] pin_out,
  output logic [7:0] pin_oe,
  input wire logic [7:0] pattern_enable_reg,
  input wire logic [7:0] pattern_out,
  input wire logic [7:0] alt_out,
  input wire logic [7:0] alt_out_en,
  input wire logic b_io_ctrl_top,
  input wire logic b_io_ctrl_mid,
  input wire logic b_io_ctrl_low,
  input wire logic ch2_pwm_mode,
  input wire logic timer_ch2_b_out,
  output logic timer_ch2_b_capture,
  output logic [7:0] pin_level
);
  if (width != 8)
  begin : g_width_check
    $error("esio_port supports width 8 only");
  end

  typedef struct packed {
    logic [7:0] dir;
    logic [7:0] data;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [7:0] rdata;
  } esio_state_s;

  esio_state_s state;
  esio_state_s next_state;
  logic ch2_b_compare;

  // compare output when top bit 0 and any lower bit set
  assign ch2_b_compare = !b_io_ctrl_top && (b_io_ctrl_mid || b_io_ctrl_low);

  always_comb
  begin
    next_state = state;
    next_state.sync1 = pin_in;
    next_state.sync2 = state.sync1;
    next_state.rdata = esio_pkg::unmapped_read_value;
    if (reg_write && reg_addr == esio_pkg::dir_addr)
    begin
      next_state.dir = reg_wdata;
    end
    if (reg_write && reg_addr == esio_pkg::data_addr)
    begin
      next_state.data = reg_wdata;
    end
    if (reg_read && reg_addr == esio_pkg::dir_addr)
    begin
      next_state.rdata = esio_pkg::dir_read_value;
    end
    if (reg_read && reg_addr == esio_pkg::data_addr)
    begin
      next_state.rdata = (state.dir & state.data) | (~state.dir & state.sync2);
    end
    // software standby changes nothing; hardware standby clears
    if (hw_standby)
    begin
      next_state.dir = esio_pkg::dir_reset;
      next_state.data = esio_pkg::data_reset;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state.dir <= esio_pkg::dir_reset;
      state.data <= esio_pkg::data_reset;
      state.sync1 <= 8'h00;
      state.sync2 <= 8'h00;
      state.rdata <= 8'h00;
    end
    else
    begin
      state <= next_state;
    end
  end

  // pin muxing; identical in all operating modes
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      if (alt_out_en[i])
      begin
        pin_oe[i] = 1'b1;
        pin_out[i] = alt_out[i];
      end
      else
      begin
        pin_oe[i] = state.dir[i];
        pin_out[i] = pattern_enable_reg[i] ? pattern_out[i] : state.data[i];
      end
    end
    if (ch2_b_compare)
    begin
      pin_oe[esio_pkg::bit7_index] = 1'b1;
      pin_out[esio_pkg::bit7_index] = timer_ch2_b_out;
    end
    else
    begin
      pin_oe[esio_pkg::bit7_index] = state.dir[esio_pkg::bit7_index];
      pin_out[esio_pkg::bit7_index] = pattern_enable_reg[esio_pkg::bit7_index] ?
        pattern_out[esio_pkg::bit7_index] : state.data[esio_pkg::bit7_index];
    end
  end

  // capture path only while bit 7 is not a timer output
  assign timer_ch2_b_capture = !ch2_b_compare && b_io_ctrl_top && !ch2_pwm_mode &&
    state.sync2[esio_pkg::bit7_index];
  assign pin_level = state.sync2;
  assign reg_rdata = state.rdata;
endmodule // esio_port
`default_nettype wire

/* hw/esio_pkg.sv */
// package of constants for the eight-bit shared io port
package esio_pkg;
  localparam logic [15:0] dir_addr = 16'hffd1;
  localparam logic [15:0] data_addr = 16'hffd3;
  localparam logic [7:0] dir_reset = 8'h00;
  localparam logic [7:0] data_reset = 8'h00;
  localparam logic [7:0] dir_read_value = 8'hff;
  localparam logic [7:0] unmapped_read_value = 8'h00;
  localparam int bit7_index = 7;
endpackage

/* tb/esio_pins.sv */
// far-side pin model for the shared io port
`timescale 1ns/100ps
`default_nettype none
module esio_pins #(parameter logic [7:0] ext = 8'h3c) (
  input wire logic [7:0] pin_out,
  input wire logic [7:0] pin_oe,
  output logic [7:0] pin_in);
  assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // esio_pins
`default_nettype wire

/* tb/esio_port_monitor.sv */
// checker of the shared io port
`timescale 1ns/100ps
`default_nettype none
module esio_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic hw_standby,
  input wire logic [15:0] reg_addr,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] pin_oe,
  input wire logic [7:0] pin_level,
  input wire logic b_io_ctrl_top,
  input wire logic b_io_ctrl_mid,
  input wire logic ch2_pwm_mode,
  input wire logic timer_ch2_b_capture);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_dir_ones: assert property (reg_read && reg_addr == 16'hffd1 |=> reg_rdata == 8'hff)
    else $error("dir read");
  a_even_none: assert property (reg_read && !reg_addr[0] |=> !reg_rdata) else $error("gap");
  a_rd_idle: assert property (!$past(reg_read) |-> !reg_rdata) else $error("idle");
  a_rst_oe: assert property ($rose(rst_n) |-> !pin_oe) else $error("reset oe");
  a_hw_clr: assert property (hw_standby ##1 !b_io_ctrl_mid |-> !pin_oe) else $error("hw");
  a_cmp_oe: assert property (!b_io_ctrl_top && b_io_ctrl_mid |-> pin_oe[7]) else $error("cmp");
  a_cap_off: assert property ((!b_io_ctrl_top || ch2_pwm_mode) [*2] |-> !timer_ch2_b_capture)
    else $error("cap");
  a_cap_lvl: assert property ((b_io_ctrl_top && !ch2_pwm_mode && $stable(pin_level[7])) [*3]
    |-> timer_ch2_b_capture == pin_level[7]) else $error("lvl");
  c_dir_rd: cover property (reg_read && reg_addr == 16'hffd1);
  c_hw: cover property (hw_standby);
  c_cmp: cover property (!b_io_ctrl_top && b_io_ctrl_mid);
endmodule // esio_monitor
bind esio_port esio_monitor esio_monitor_i (.*);
`default_nettype wire

/* tb/test_eight_bit_shared_io_port.sv */
// testbench of the shared io port
`timescale 1ns/100ps
`default_nettype none
module test_eight_bit_shared_io_port;
  logic sys_clk = 0, rst_n = 0, hw_standby = 0, sw_standby = 0, reg_write = 0, reg_read = 0;
  logic b_io_ctrl_top = 0, b_io_ctrl_mid = 0, b_io_ctrl_low = 0, ch2_pwm_mode = 0;
  logic timer_ch2_b_out = 1, timer_ch2_b_capture;
  logic [15:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata, pin_in, pin_out, pin_oe, pin_level, alt_out = 0;
  logic [7:0] pattern_enable_reg = 0, pattern_out = 0, alt_out_en = 0;
  int n_errors = 0, n_checks = 0;
  esio_port esio_port_i (.*);
  esio_pins esio_pins_i (.*);
  always #25 sys_clk = ~sys_clk;
  task chk(input string n, input logic [7:0] e, s);
    n_checks++;
    if (s !== e) $display("unexpected %s exp %h got %h", n, e, s);
    n_errors += (s !== e);
  endtask
  task acc(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk) {reg_write, reg_read, reg_addr, reg_wdata} <= {w, !w, a, d};
    @(posedge sys_clk) {reg_write, reg_read} <= 2'h0;
    #1;
  endtask
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst_n <= 1;
    acc(1, 16'hffd3, 8'ha5);
    acc(0, 16'hffd3, 0); chk("data", 8'h3c, reg_rdata);
    acc(0, 16'hffd1, 0); chk("dir", 8'hff, reg_rdata);
    @(posedge sys_clk) sw_standby <= 1;
    acc(1, 16'hffd1, 8'h0f);
    acc(0, 16'hffd3, 0); chk("data", 8'h35, reg_rdata);
    chk("oe", 8'h0f, pin_oe);
    @(posedge sys_clk) hw_standby <= 1;
    acc(0, 16'hffd4, 0); chk("none", 8'h00, reg_rdata);
    @(posedge sys_clk) {hw_standby, b_io_ctrl_mid} <= 2'h1;
    acc(1, 16'hffd1, 8'hff);
    chk("out", 8'h80, pin_out);
    @(posedge sys_clk)
      {b_io_ctrl_top, b_io_ctrl_mid, timer_ch2_b_out, pattern_enable_reg, pattern_out} <= 19'h48080;
    acc(0, 16'hffd3, 0); chk("data", 8'h00, reg_rdata);
    chk("out", 8'h80, pin_out);
    repeat (3) @(posedge sys_clk);
    #1;
    chk("level", 8'h80, pin_level);
    chk("cap", 8'h01, {7'h00, timer_ch2_b_capture});
    report_and_stop;
  end
  initial #100000 begin n_errors++; report_and_stop; end
endmodule // test_eight_bit_shared_io_port
`default_nettype wire
